/* bench/hqsp_link_monitor.sv */
module hqsp_link_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic req_n,
    input wire logic dev_rx,
    input wire logic dev_tx,
    input wire logic asleep,
    input wire logic cal_active,
    input wire logic sample_req
);
    timeunit 1ns;
    timeprecision 100ps;

    // One clock domain, so clock and reset are given once
    default clocking mon_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // A sleeping sender must leave its line at the idle level
    sleep_line_idle_a: assert property (asleep |-> dev_tx)
        else $error("transmit line low while asleep");
    query_sample_a: assert property ($fell(req_n) && dev_rx && asleep |-> ##[0:2] sample_req)
        else $error("request pulse gave no sample");
    sample_pulse_a: assert property (sample_req |=> !sample_req)
        else $error("sample strobe longer than one cycle");
    sample_start_a: assert property (sample_req |=> ##[0:1] !dev_tx)
        else $error("no start bit after sample");
    cal_entry_a: assert property ($fell(req_n) && !dev_rx && asleep |-> ##[0:2] cal_active)
        else $error("calibration not entered");
    cal_no_reply_a: assert property (cal_active |-> !sample_req)
        else $error("heading sampled during calibration");
    // Past value spans the first low cycles, so a pulse that just began is not judged
    stream_awake_a: assert property (!req_n && !$past(req_n, 3) && !cal_active |-> !asleep)
        else $error("asleep while request held low");
    cal_done_send_a: assert property ($rose(dev_rx) && cal_active |-> ##[1:30] $fell(dev_tx))
        else $error("done marker did not start");
    cal_end_sleep_a: assert property ($fell(cal_active) |-> ##[0:2] asleep)
        else $error("no sleep after calibration");
endmodule

/* bench/test_heading_query_serial_port.sv */
module test_heading_query_serial_port;
    import hqsp_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    // Scaled clock keeps the long hold and period timers affordable
    localparam int unsigned TB_HZ = 48000;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        strap_hi = 1'b0;
    logic        strap_lo = 1'b1;
    logic        inv_strap = 1'b1;
    logic [15:0] heading = 16'h0;
    logic        distort = 1'b0;
    logic        asleep;
    logic        cal_active;
    logic        sample_req;
    int          error_cnt = 0;
    int          n_compared = 0;
    int          cycles = 0;
    logic [31:0] rd;
    logic        err;
    // Case table: strap code, heading, distortion, invert strap, expected reply
    logic [1:0]  t_code [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
    logic [15:0] t_head [4] = '{16'h0285, 16'h0064, 16'h0400, 16'h0000};
    logic        t_dist [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    logic        t_inv  [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic [23:0] t_exp  [4] = '{24'h800285, 24'h81026c, 24'h8002cf, 24'h810000};
    int          t_div  [4] = '{20, 10, 5, 3};

    hqsp_link_if link ();

    hqsp_device #(.clk_hz(TB_HZ)) i_hqsp_device (
        .pclk(pclk), .presetn(presetn), .link(link), .baud_strap_high(strap_hi),
        .baud_strap_low(strap_lo), .x_axis_invert_strap(inv_strap), .heading_in(heading),
        .distort_in(distort), .asleep(asleep), .cal_active(cal_active),
        .sample_req(sample_req)
    );

    hqsp_host #(.clk_hz(TB_HZ)) i_hqsp_host (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link)
    );

    hqsp_link_monitor i_hqsp_link_monitor (
        .pclk(pclk), .presetn(presetn), .req_n(link.req_n), .dev_rx(link.dev_rx),
        .dev_tx(link.dev_tx), .asleep(asleep), .cal_active(cal_active),
        .sample_req(sample_req)
    );

    always #2.5 pclk = ~pclk;

    // Hang guard, well above the expected run length
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            error_cnt++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // APB transfer; data and error taken at the edge where pready is seen
    task automatic apb(logic wr, logic [7:0] addr, logic [31:0] wdata);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Straps are latched just after release, so they are set while in reset
    task automatic do_reset(logic [1:0] code);
        @(posedge pclk);
        presetn <= 1'b0;
        {strap_hi, strap_lo} <= code;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask

    // Receives one 8N1 frame, sampling mid bit
    task automatic rx_byte(int div, output logic [7:0] b);
        int n;
        n = 0;
        while (link.dev_tx !== 1'b0 && n < 40000) begin
            @(posedge pclk);
            n++;
        end
        repeat (div / 2) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            repeat (div) @(posedge pclk);
            b[i] = link.dev_tx;
        end
        repeat (div) @(posedge pclk);
        chk("stop bit", 32'h1, {31'h0, link.dev_tx});
    endtask

    task automatic rx3(int div, logic [23:0] exp);
        logic [7:0] b;
        for (int i = 2; i >= 0; i--) begin
            rx_byte(div, b);
            chk("message byte", {24'h0, exp[i*8+:8]}, {24'h0, b});
        end
    endtask

    task automatic wait_sleep();
        int n;
        n = 0;
        while (asleep !== 1'b1 && n < 5000) begin
            @(posedge pclk);
            n++;
        end
        chk("asleep", 32'h1, {31'h0, asleep});
    endtask

    initial begin
        do_reset(2'h1);
        // Ready straight after power-up, reset values, unmapped place
        apb(1'b0, REG_CTRL, 32'h0);
        chk("ctrl reset", 32'h10, rd);
        apb(1'b0, REG_STATUS, 32'h0);
        chk("status reset", 32'h0, rd);
        apb(1'b0, 8'h0c, 32'h0);
        chk("unmapped data", 32'h0, rd);
        chk("unmapped error", 32'h1, {31'h0, err});
        $display("Test reset done");
        // Every baud code, distortion flag, inversion and clamp
        for (int i = 0; i < 4; i++) begin
            heading <= t_head[i];
            distort <= t_dist[i];
            inv_strap <= t_inv[i];
            do_reset(t_code[i]);
            apb(1'b1, REG_CTRL, {26'h0, t_code[i], 4'h1});
            rx3(t_div[i], t_exp[i]);
            repeat (25) @(posedge pclk);
            apb(1'b0, REG_STATUS, 32'h0);
            chk("status after reply", 32'h3, rd);
            apb(1'b0, REG_REPLY, 32'h0);
            chk("reply register", {15'h0, t_dist[i], t_exp[i][15:0]}, rd);
            apb(1'b1, REG_STATUS, 32'h2);
            // A query inside the spacing window must be refused
            apb(1'b1, REG_CTRL, {26'h0, t_code[i], 4'h1});
            repeat (700) @(posedge pclk);
            apb(1'b0, REG_STATUS, 32'h0);
            chk("refused query", 32'h1, rd);
            wait_sleep();
            $display("Test query code %0d done", t_code[i]);
        end
        // Continuous stream at 19200 baud
        apb(1'b1, REG_CTRL, 32'h2);
        rx3(3, 24'h810000);
        repeat (1500) @(posedge pclk);
        chk("awake in stream", 32'h0, {31'h0, asleep});
        rx3(3, 24'h810000);
        apb(1'b1, REG_CTRL, 32'h0);
        wait_sleep();
        $display("Test continuous done");
        // Calibration start and done markers
        apb(1'b1, REG_STATUS, 32'he);
        // Cal and cont in one write are both refused, so no request goes out
        apb(1'b1, REG_CTRL, 32'h6);
        apb(1'b0, REG_CTRL, 32'h0);
        chk("cal with cont", 32'h0, rd);
        repeat (150) @(posedge pclk);
        apb(1'b0, REG_STATUS, 32'h0);
        chk("no stray reply", 32'h0, rd & 32'he);
        apb(1'b1, REG_CTRL, 32'h4);
        rx3(3, 24'h535441);
        repeat (10) @(posedge pclk);
        apb(1'b0, REG_STATUS, 32'h0);
        chk("cal start seen", 32'h4, rd & 32'h4);
        chk("cal active", 32'h1, {31'h0, cal_active});
        apb(1'b1, REG_CTRL, 32'h0);
        rx3(3, 24'h524459);
        wait_sleep();
        apb(1'b0, REG_STATUS, 32'h0);
        chk("cal done seen", 32'h8, rd & 32'h8);
        chk("cal ended", 32'h0, {31'h0, cal_active});
        $display("Test calibration done");
        stop_test();
    end
endmodule

/* hw/hqsp_device.sv */
// Chosen here: the APB interface to the registers and the placing of the registers.
module hqsp_device
    import hqsp_pkg::*;
#(
    parameter int unsigned clk_hz = CLK_HZ
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    hqsp_link_if.dev         link,
    input  wire logic        baud_strap_high,
    input  wire logic        baud_strap_low,
    input  wire logic        x_axis_invert_strap,
    input  wire logic [15:0] heading_in,
    input  wire logic        distort_in,
    output logic             asleep,
    output logic             cal_active,
    output logic             sample_req
);

    typedef enum logic [6:0] {
        S_SLEEP     = 7'h01,
        S_REPLY     = 7'h02,
        S_HOLD      = 7'h04,
        S_CONT      = 7'h08,
        S_CAL_START = 7'h10,
        S_CAL       = 7'h20,
        S_CAL_DONE  = 7'h40
    } hqsp_dev_state_e;

    localparam logic [31:0] HOLD_CYC = ms_cycles(clk_hz, HOLD_MS);
    localparam logic [31:0] PER_CYC  = ms_cycles(clk_hz, CONT_PERIOD_MS);

    hqsp_dev_state_e state;
    logic            straps_taken;
    logic [1:0]      baud_sel;
    logic            invert_x;
    logic [31:0]     bit_div;
    logic            req_prev;
    logic            req_fall;
    logic [31:0]     low_cnt;
    logic            low_past;
    logic [31:0]     per_cnt;
    logic            per_done;
    logic            load;
    logic [23:0]     load_msg;
    logic            load_reply;
    logic [15:0]     heading_fix;
    logic [23:0]     msg;
    logic [3:0]      bit_idx;
    logic [1:0]      byte_idx;
    logic [31:0]     div_cnt;
    logic            sending;
    logic            tick;
    logic            send_done;
    logic            tx;

    // Straps are caught once after reset release, never under reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            straps_taken <= 1'b0;
            baud_sel     <= BAUD_RESET;
            invert_x     <= 1'b0;
        end else if (!straps_taken) begin
            straps_taken <= 1'b1;
            baud_sel     <= {baud_strap_high, baud_strap_low};
            invert_x     <= ~x_axis_invert_strap;
        end
    end

    assign bit_div = baud_div(clk_hz, baud_sel);

    // Request edge and how long the line has stayed low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_prev <= 1'b1;
            low_cnt  <= 32'h0;
        end else begin
            req_prev <= link.req_n;
            if (link.req_n)
                low_cnt <= 32'h0;
            else if (!low_past)
                low_cnt <= low_cnt + 32'h1;
        end
    end

    assign req_fall = req_prev && !link.req_n;
    assign low_past = low_cnt >= HOLD_CYC;

    // Streaming period, only runs while in continuous wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            per_cnt <= 32'h0;
        else if (state != S_CONT || per_done)
            per_cnt <= 32'h0;
        else
            per_cnt <= per_cnt + 32'h1;
    end

    assign per_done = (state == S_CONT) && (per_cnt == PER_CYC - 32'h1);

    // Clamp to a legal field, then mirror when mounted upside down
    always_comb begin
        heading_fix = (heading_in > HEADING_MAX) ? HEADING_MAX : heading_in;
        if (invert_x && heading_fix != 16'h0)
            heading_fix = HALF_CIRCLE - heading_fix;
    end

    // Which message starts this cycle
    always_comb begin
        load       = 1'b0;
        load_reply = 1'b0;
        load_msg   = {HDR_OK, heading_fix};
        case (state)
            S_SLEEP: begin
                if (req_fall && !link.dev_rx) begin
                    load     = 1'b1;
                    load_msg = CAL_START_MARK;
                end else if (req_fall) begin
                    load       = 1'b1;
                    load_reply = 1'b1;
                end
            end
            S_CONT: begin
                if (per_done && !link.req_n) begin
                    load       = 1'b1;
                    load_reply = 1'b1;
                end
            end
            S_CAL: begin
                if (link.dev_rx) begin
                    load     = 1'b1;
                    load_msg = CAL_DONE_MARK;
                end
            end
            default: begin
                load = 1'b0;
            end
        endcase
        if (load_reply)
            load_msg = {(distort_in ? HDR_DISTORT : HDR_OK), heading_fix};
    end

    // Mode sequencing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= S_SLEEP;
        end else begin
            case (state)
                S_SLEEP: begin
                    if (load && !load_reply)
                        state <= S_CAL_START;
                    else if (load)
                        state <= S_REPLY;
                end
                S_REPLY: begin
                    if (send_done && link.req_n)
                        state <= S_SLEEP;
                    else if (send_done && low_past)
                        state <= S_CONT;
                    else if (send_done)
                        state <= S_HOLD;
                end
                S_HOLD: begin
                    if (link.req_n)
                        state <= S_SLEEP;
                    else if (low_past)
                        state <= S_CONT;
                end
                S_CONT: begin
                    if (link.req_n)
                        state <= S_SLEEP;
                    else if (load)
                        state <= S_REPLY;
                end
                S_CAL_START: begin
                    if (send_done)
                        state <= S_CAL;
                end
                S_CAL: begin
                    if (load)
                        state <= S_CAL_DONE;
                end
                S_CAL_DONE: begin
                    if (send_done)
                        state <= S_SLEEP;
                end
                default: begin
                    state <= S_SLEEP;
                end
            endcase
        end
    end

    assign tick      = sending && (div_cnt == bit_div - 32'h1);
    assign send_done = tick && (bit_idx == 4'd9) && (byte_idx == 2'd2);

    // Three-byte sender; start bit, eight data bits LSB first, stop bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msg      <= 24'h0;
            bit_idx  <= 4'h0;
            byte_idx <= 2'h0;
            div_cnt  <= 32'h0;
            sending  <= 1'b0;
            tx       <= 1'b1;
        end else if (load) begin
            msg      <= load_msg;
            bit_idx  <= 4'h0;
            byte_idx <= 2'h0;
            div_cnt  <= 32'h0;
            sending  <= 1'b1;
            tx       <= 1'b0;
        end else if (tick) begin
            div_cnt <= 32'h0;
            if (bit_idx == 4'(FRAME_BITS - 1)) begin
                if (byte_idx == 2'd2) begin
                    sending <= 1'b0;
                end else begin
                    byte_idx <= byte_idx + 2'h1;
                    msg      <= {msg[15:0], 8'h00};
                    bit_idx  <= 4'h0;
                    tx       <= 1'b0;
                end
            end else begin
                bit_idx <= bit_idx + 4'h1;
                // Stop bit after the eighth data bit, no parity
                tx      <= (bit_idx == 4'd8) ? 1'b1 : msg[16 + 32'(bit_idx[2:0])];
            end
        end else if (sending) begin
            div_cnt <= div_cnt + 32'h1;
        end
    end

    assign link.dev_tx = tx;

    // Status toward the sensor side
    assign asleep     = (state == S_SLEEP) && !sending;
    assign cal_active = (state == S_CAL_START) || (state == S_CAL) || (state == S_CAL_DONE);
    // The sensor samples as the reply is captured, so the reply carries the heading from before this sample
    assign sample_req = load_reply;

endmodule

/* hw/hqsp_host.sv */
module hqsp_host
    import hqsp_pkg::*;
#(
    parameter int unsigned clk_hz = CLK_HZ
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    hqsp_link_if.host        link
);

    localparam logic [31:0] PULSE_CYC = ms_cycles(clk_hz, PULSE_MS);
    localparam logic [31:0] GAP_CYC   = ms_cycles(clk_hz, QUERY_GAP_MS);

    logic        wr_en;
    logic        ctrl_wr;
    logic        query_go;
    logic        cal_go;
    logic        ctrl_cont;
    logic        ctrl_cal;
    logic [1:0]  baud_sel;
    logic [31:0] pulse_cnt;
    logic [31:0] gap_cnt;
    logic [3:0]  flags;
    logic [16:0] reply;
    logic [31:0] bit_div;
    logic        rx_on;
    logic [3:0]  rx_bit;
    logic [31:0] rx_cnt;
    logic [7:0]  rx_shift;
    logic        byte_done;
    logic [1:0]  fr_idx;
    logic [7:0]  fr_hdr;
    logic [7:0]  fr_mid;
    logic        set_reply;
    logic        set_start;
    logic        set_done;

    assign wr_en   = psel && penable && pwrite;
    assign ctrl_wr = wr_en && (paddr == REG_CTRL);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && (paddr != REG_CTRL) && (paddr != REG_STATUS)
                     && (paddr != REG_REPLY);
    assign bit_div = baud_div(clk_hz, baud_sel);
    // Queries too close together or during other modes are dropped
    assign query_go = ctrl_wr && pwdata[CTRL_QUERY] && gap_cnt == 32'h0
                      && !ctrl_cont && !ctrl_cal;
    // Cal written with cont is refused outright, so no stray request pulse
    assign cal_go   = ctrl_wr && pwdata[CTRL_CAL] && !pwdata[CTRL_CONT]
                      && !ctrl_cal && !ctrl_cont;

    // Control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_cont <= 1'b0;
            ctrl_cal  <= 1'b0;
            baud_sel  <= BAUD_RESET;
        end else if (ctrl_wr) begin
            ctrl_cont <= pwdata[CTRL_CONT] && !pwdata[CTRL_CAL];
            ctrl_cal  <= pwdata[CTRL_CAL] && !pwdata[CTRL_CONT];
            baud_sel  <= pwdata[CTRL_BAUD +: 2];
        end
    end

    // Pulse and spacing timers drive the link pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_cnt   <= 32'h0;
            gap_cnt     <= 32'h0;
            link.req_n  <= 1'b1;
            link.dev_rx <= 1'b1;
        end else begin
            if (query_go || cal_go)
                pulse_cnt <= PULSE_CYC;
            else if (pulse_cnt != 32'h0)
                pulse_cnt <= pulse_cnt - 32'h1;
            if (query_go)
                gap_cnt <= GAP_CYC;
            else if (gap_cnt != 32'h0)
                gap_cnt <= gap_cnt - 32'h1;
            // High except during a pulse or a held stream
            link.req_n  <= !(query_go || cal_go || pulse_cnt > 32'h1
                             || (ctrl_wr ? pwdata[CTRL_CONT] && !pwdata[CTRL_CAL]
                                         : ctrl_cont));
            link.dev_rx <= ctrl_wr ? !(pwdata[CTRL_CAL] && !pwdata[CTRL_CONT])
                                   : !ctrl_cal;
        end
    end

    // Receiver samples mid-bit; a false start is dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_on    <= 1'b0;
            rx_bit   <= 4'h0;
            rx_cnt   <= 32'h0;
            rx_shift <= 8'h0;
        end else if (!rx_on) begin
            rx_on  <= !link.dev_tx;
            rx_bit <= 4'h0;
            rx_cnt <= bit_div >> 1;
        end else if (rx_cnt != 32'h0) begin
            rx_cnt <= rx_cnt - 32'h1;
        end else begin
            rx_cnt <= bit_div - 32'h1;
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == 4'h0 && link.dev_tx)
                rx_on <= 1'b0;
            else if (rx_bit == 4'(FRAME_BITS - 1))
                rx_on <= 1'b0;
            else if (rx_bit != 4'h0)
                rx_shift <= {link.dev_tx, rx_shift[7:1]};
        end
    end

    assign byte_done = rx_on && rx_cnt == 32'h0 && rx_bit == 4'(FRAME_BITS - 1) && link.dev_tx;
    assign set_reply = byte_done && fr_idx == 2'd2 && fr_hdr[7:1] == HDR_OK[7:1];
    assign set_start = byte_done && fr_idx == 2'd2
                       && {fr_hdr, fr_mid, rx_shift} == CAL_START_MARK;
    assign set_done  = byte_done && fr_idx == 2'd2
                       && {fr_hdr, fr_mid, rx_shift} == CAL_DONE_MARK;

    // Frame assembly; resync on a byte that opens no known message
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fr_idx <= 2'h0;
            fr_hdr <= 8'h0;
            fr_mid <= 8'h0;
            reply  <= 17'h0;
        end else if (byte_done) begin
            case (fr_idx)
                2'd0: begin
                    fr_hdr <= rx_shift;
                    if (rx_shift[7:1] == HDR_OK[7:1] || rx_shift == CAL_START_MARK[23:16]
                        || rx_shift == CAL_DONE_MARK[23:16])
                        fr_idx <= 2'd1;
                end
                2'd1: begin
                    fr_mid <= rx_shift;
                    fr_idx <= 2'd2;
                end
                default: begin
                    fr_idx <= 2'd0;
                    if (set_reply)
                        reply <= {fr_hdr[0], fr_mid, rx_shift};
                end
            endcase
        end
    end

    // Sticky status; a new event beats a same-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            flags <= 4'h0;
        else begin
            if (wr_en && paddr == REG_STATUS)
                flags <= flags & ~pwdata[3:0];
            if (set_reply)
                flags[ST_REPLY] <= 1'b1;
            if (set_start)
                flags[ST_CAL_START] <= 1'b1;
            if (set_done)
                flags[ST_CAL_DONE] <= 1'b1;
        end
    end

    // Read mux
    always_comb begin
        prdata = 32'h0;
        case (paddr)
            REG_CTRL: begin
                prdata[CTRL_CONT]      = ctrl_cont;
                prdata[CTRL_CAL]       = ctrl_cal;
                prdata[CTRL_BAUD +: 2] = baud_sel;
            end
            REG_STATUS: begin
                prdata[3:0]     = flags;
                prdata[ST_BUSY] = rx_on || pulse_cnt != 32'h0 || gap_cnt != 32'h0;
            end
            REG_REPLY: prdata[16:0] = reply;
            default:   prdata = 32'h0;
        endcase
    end

endmodule

/* hw/hqsp_link_if.sv */
interface hqsp_link_if;
    logic req_n;
    logic dev_rx;
    logic dev_tx;
    modport dev  (input req_n, input dev_rx, output dev_tx);
    modport host (output req_n, output dev_rx, input dev_tx);
endinterface

/* hw/hqsp_pkg.sv */
// Behaviour
// - Strap absent reads 1, fitted reads 0
// - Straps pick 2400, 4800, 9600, 19200 baud
// - Eight data bits, no parity, one stop
// - Invert strap fitted mirrors the X axis
// - Answers requests straight after power-up
// - Each low request pulse gives one reply
// - Host keeps receive line high normally
// - Host keeps request high between pulses
// - Sleep after reply if request high
// - At most twenty requests per second
// - Request held low streams replies under 2 Hz
// - Request pulse with receive low starts calibration
// - Calibration entry sends start marker 53 54 41
// - Host raises receive line to end calibration
// - Receive high sends 52 44 59, then sleep
// - Reply is three bytes, header 80 or 81
// - Header bit zero flags suspected distortion
// - Heading sixteen bits, high byte first
// - Heading counts half degrees
package hqsp_pkg;

    localparam int unsigned CLK_HZ         = 200_000_000;
    localparam int unsigned BAUD_2400      = 2400;
    localparam int unsigned BAUD_4800      = 4800;
    localparam int unsigned BAUD_9600      = 9600;
    localparam int unsigned BAUD_19200     = 19200;
    localparam int unsigned FRAME_BITS     = 10;
    localparam int unsigned HOLD_MS        = 20;
    localparam int unsigned CONT_PERIOD_MS = 520;
    localparam int unsigned QUERY_GAP_MS   = 50;
    localparam int unsigned PULSE_MS       = 2;

    localparam logic [7:0]  HDR_OK         = 8'h80;
    localparam logic [7:0]  HDR_DISTORT    = 8'h81;
    localparam logic [23:0] CAL_START_MARK = 24'h535441;
    localparam logic [23:0] CAL_DONE_MARK  = 24'h524459;
    localparam logic [15:0] HEADING_MAX    = 16'h02cf;
    localparam logic [15:0] HALF_CIRCLE    = 16'h02d0;

    // Host register map, byte addresses
    localparam logic [7:0]  REG_CTRL       = 8'h00;
    localparam logic [7:0]  REG_STATUS     = 8'h04;
    localparam logic [7:0]  REG_REPLY      = 8'h08;
    localparam int unsigned CTRL_QUERY     = 0;
    localparam int unsigned CTRL_CONT      = 1;
    localparam int unsigned CTRL_CAL       = 2;
    localparam int unsigned CTRL_BAUD      = 4;
    localparam logic [1:0]  BAUD_RESET     = 2'h1;
    localparam int unsigned ST_BUSY        = 0;
    localparam int unsigned ST_REPLY       = 1;
    localparam int unsigned ST_CAL_START   = 2;
    localparam int unsigned ST_CAL_DONE    = 3;

    // Bit period in clocks for a strap code {high, low}
    function automatic logic [31:0] baud_div(int unsigned clk_hz, logic [1:0] sel);
        int unsigned b;
        case (sel)
            2'h3:    b = BAUD_2400;
            2'h2:    b = BAUD_4800;
            2'h1:    b = BAUD_9600;
            default: b = BAUD_19200;
        endcase
        return 32'((clk_hz + b / 2) / b);
    endfunction

    // Milliseconds to clocks, at least one
    function automatic logic [31:0] ms_cycles(int unsigned clk_hz, int unsigned ms);
        longint unsigned c;
        c = (longint'(clk_hz) * longint'(ms) + 64'd999) / 64'd1000;
        if (c == 64'd0)
            c = 64'd1;
        return c[31:0];
    endfunction

endpackage
